// >>> verilog/tpcs_pkg.sv
`default_nettype none

package tpcs_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_WIDTH = 12;
    localparam logic [11:0] ADDR_EVENT_FLAGS = 12'h000;
    localparam logic [11:0] ADDR_GENERAL_CTRL = 12'h004;
    localparam logic [11:0] ADDR_CLOCK_SELECT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h00c;

    // ------------------------------------------------------------
    // timer_event_flags layout
    // ------------------------------------------------------------
    localparam int FLAG_NARROW_CMP_A = 0;
    localparam int FLAG_NARROW_OVF = 1;
    localparam int FLAG_NARROW_CMP_B = 2;
    localparam int FLAG_WIDE_CAPTURE = 3;
    localparam int FLAG_RESERVED = 4;
    localparam int FLAG_WIDE_CMP_B = 5;
    localparam int FLAG_WIDE_CMP_A = 6;
    localparam int FLAG_WIDE_OVF = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] FLAGS_IMPLEMENTED = 8'hef;

    // ------------------------------------------------------------
    // general_timer_control and own registers
    // ------------------------------------------------------------
    localparam int PRESCALER_RESET_BIT = 0;
    localparam logic PRESCALER_RESET_RESET = 1'b0;
    localparam int NARROW_CS_LSB = 0;
    localparam int WIDE_CS_LSB = 4;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;

    // ------------------------------------------------------------
    // clock select and waveform modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TPCS_CS_STOP = 3'b000,
        TPCS_CS_DIRECT = 3'b001,
        TPCS_CS_DIV8 = 3'b010,
        TPCS_CS_DIV64 = 3'b011,
        TPCS_CS_DIV256 = 3'b100,
        TPCS_CS_DIV1024 = 3'b101,
        TPCS_CS_EXT_FALL = 3'b110,
        TPCS_CS_EXT_RISE = 3'b111
    } tpcs_clksel_t;

    localparam tpcs_clksel_t CLOCK_SELECT_RESET = TPCS_CS_STOP;

    typedef enum logic [2:0] {
        TPCS_WAVE_NORMAL = 3'b000,
        TPCS_WAVE_PHASE_FULL = 3'b001,
        TPCS_WAVE_CTC = 3'b010,
        TPCS_WAVE_FAST_FULL = 3'b011,
        TPCS_WAVE_RSVD_A = 3'b100,
        TPCS_WAVE_PHASE_CMPA = 3'b101,
        TPCS_WAVE_RSVD_B = 3'b110,
        TPCS_WAVE_FAST_CMPA = 3'b111
    } tpcs_wave_t;

    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    // ------------------------------------------------------------
    // prescaler taps, as bit counts of the 10-bit divider
    // ------------------------------------------------------------
    localparam int PRESCALE_WIDTH = 10;
    localparam int TAP_DIV8_BITS = 3;
    localparam int TAP_DIV64_BITS = 6;
    localparam int TAP_DIV256_BITS = 8;
    localparam int TAP_DIV1024_BITS = 10;

endpackage

`default_nettype wire

// >>> verilog/tpcs_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module tpcs_prescaler #(
    parameter int WIDTH = tpcs_pkg::PRESCALE_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic syncClear,
    // divide taps, one-cycle strobes
    output logic tapDiv8,
    output logic tapDiv64,
    output logic tapDiv256,
    output logic tapDiv1024
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } tpcs_presc_state_t;

    tpcs_presc_state_t state_reg;
    tpcs_presc_state_t state_next;

    function automatic logic tapHit(input logic [WIDTH-1:0] c, input int n);
        logic [WIDTH-1:0] m;
        m = WIDTH'((1 << n) - 1);
        return (c & m) == m;
    endfunction

    // ------------------------------------------------------------
    // free-running divider
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (syncClear) begin
            state_next.count = '0;
        end else begin
            state_next.count = state_reg.count + WIDTH'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // carry outputs; a clear swallows the pending carry
    assign tapDiv8 = !syncClear && tapHit(state_reg.count, tpcs_pkg::TAP_DIV8_BITS);
    assign tapDiv64 = !syncClear && tapHit(state_reg.count, tpcs_pkg::TAP_DIV64_BITS);
    assign tapDiv256 = !syncClear && tapHit(state_reg.count, tpcs_pkg::TAP_DIV256_BITS);
    assign tapDiv1024 = !syncClear && tapHit(state_reg.count, tpcs_pkg::TAP_DIV1024_BITS);

endmodule

`default_nettype wire

// >>> verilog/tpcs_pin_edge.sv
`timescale 1ns/10ps
`default_nettype none

module tpcs_pin_edge (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // asynchronous count pin
    input wire logic pinLevel,
    // edge strobes, one cycle each
    output logic risePulse,
    output logic fallPulse
);

    typedef struct packed {
        logic stageOne;
        logic stageTwo;
    } tpcs_edge_state_t;

    tpcs_edge_state_t state_reg;
    tpcs_edge_state_t state_next;
    logic pinLatch;

    // ------------------------------------------------------------
    // sampler: latch open while clk is high, then two flops
    // ------------------------------------------------------------
    // latch acts as the first synchroniser stage; only stageOne reads it
    always_latch begin
        if (clk) begin
            pinLatch = pinLevel;
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.stageOne = pinLatch;
        state_next.stageTwo = state_reg.stageOne;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // one strobe per edge, compared across the two flops
    assign risePulse = state_reg.stageOne && !state_reg.stageTwo;
    assign fallPulse = !state_reg.stageOne && state_reg.stageTwo;

endmodule

`default_nettype wire

// >>> verilog/tpcs_top.sv
// Contract
// - narrow compare-B flag, bit 2, sets when count equals compare-B value
// - narrow overflow flag, bit 1, sets per waveform mode condition
// - narrow compare-A flag, bit 0, sets when count equals compare-A value
// - flags clear on vector acknowledge or on writing one to the bit
// - interrupt requested only with global enable, source enable and flag
// - flag bit 4 is read-only and reads zero
// - one shared prescaler, separate clock select per timer
// - select 1 is system clock; selects 2 to 5 taps of 8, 64, 256, 1024
// - prescaler runs freely regardless of clock selections
// - first prescaled count arrives 1 to N+1 cycles after enabling; this design takes 1 to N
// - count pin sampled per clock via high-transparent latch then flops
// - one tick per edge: rising for select 7, falling for 6
// - external edge reaches the counter 2.5 to 3.5 cycles later; this design takes 1.5 to 2.5
// - external edges bypass the prescaler and drive the counter directly
// - writing one to control bit 0 resets the prescaler, self-clears
// - control bits 7 to 1 reserved, read as zero
// - select zero gives no clock, timer stopped
// - pin edges count even if pin is an output
`timescale 1ns/10ps
`default_nettype none

module tpcs_top (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu interrupt side
    input wire logic globalIrqEnable,
    input wire logic [7:0] flagAck,
    output logic [7:0] irqRequest,
    // narrow counter core
    input wire logic [7:0] narrowCountValue,
    input wire logic [7:0] narrowCompareAValue,
    input wire logic [7:0] narrowCompareBValue,
    input wire logic [2:0] waveformModeSelect,
    output logic narrowTimerTick,
    output logic [2:0] narrowClockSelect,
    // wide counter core events
    input wire logic wideOverflowEvent,
    input wire logic wideCompareAEvent,
    input wire logic wideCompareBEvent,
    input wire logic wideCaptureEvent,
    output logic wideTimerTick,
    output logic [2:0] wideClockSelect,
    // external count pins
    input wire logic narrowCountPin,
    input wire logic wideCountPin
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] eventFlags;
        logic prescalerReset;
        logic [2:0] narrowSelect;
        logic [2:0] wideSelect;
        logic [7:0] irqEnable;
        logic [31:0] readData;
        logic readError;
    } tpcs_state_t;

    tpcs_state_t state_reg;
    tpcs_state_t state_next;

    logic tapDiv8;
    logic tapDiv64;
    logic tapDiv256;
    logic tapDiv1024;
    logic narrowRise;
    logic narrowFall;
    logic wideRise;
    logic wideFall;
    logic setupPhase;
    logic writeStrobe;
    logic addrMapped;
    logic [7:0] flagSet;
    logic [7:0] flagClear;
    logic [7:0] overflowLevel;
    logic overflowHit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic tickFor(
        input logic [2:0] sel,
        input logic rise,
        input logic fall,
        input logic [3:0] taps
    );
        logic hit;
        hit = 1'b0;
        unique case (tpcs_pkg::tpcs_clksel_t'(sel))
            tpcs_pkg::TPCS_CS_STOP: hit = 1'b0;
            tpcs_pkg::TPCS_CS_DIRECT: hit = 1'b1;
            tpcs_pkg::TPCS_CS_DIV8: hit = taps[0];
            tpcs_pkg::TPCS_CS_DIV64: hit = taps[1];
            tpcs_pkg::TPCS_CS_DIV256: hit = taps[2];
            tpcs_pkg::TPCS_CS_DIV1024: hit = taps[3];
            tpcs_pkg::TPCS_CS_EXT_FALL: hit = fall;
            tpcs_pkg::TPCS_CS_EXT_RISE: hit = rise;
        endcase
        return hit;
    endfunction

    function automatic logic isAddr(
        input logic [11:0] a,
        input logic [11:0] b
    );
        return a == b;
    endfunction

    // ------------------------------------------------------------
    // shared prescaler and pin samplers
    // ------------------------------------------------------------
    tpcs_prescaler #(
        .WIDTH(tpcs_pkg::PRESCALE_WIDTH)
    ) sharedPrescaler (
        .clk(clk),
        .reset_n(reset_n),
        .syncClear(state_reg.prescalerReset),
        .tapDiv8(tapDiv8),
        .tapDiv64(tapDiv64),
        .tapDiv256(tapDiv256),
        .tapDiv1024(tapDiv1024)
    );

    // pin direction is not seen here, so an output pin still counts
    tpcs_pin_edge narrowPinEdge (
        .clk(clk),
        .reset_n(reset_n),
        .pinLevel(narrowCountPin),
        .risePulse(narrowRise),
        .fallPulse(narrowFall)
    );

    tpcs_pin_edge widePinEdge (
        .clk(clk),
        .reset_n(reset_n),
        .pinLevel(wideCountPin),
        .risePulse(wideRise),
        .fallPulse(wideFall)
    );

    // ------------------------------------------------------------
    // timer clock selection
    // ------------------------------------------------------------
    // selections switched while the pin moves may give a false tick
    assign narrowTimerTick = tickFor(
        state_reg.narrowSelect,
        narrowRise,
        narrowFall,
        {tapDiv1024, tapDiv256, tapDiv64, tapDiv8}
    );

    assign wideTimerTick = tickFor(
        state_reg.wideSelect,
        wideRise,
        wideFall,
        {tapDiv1024, tapDiv256, tapDiv64, tapDiv8}
    );

    assign narrowClockSelect = state_reg.narrowSelect;
    assign wideClockSelect = state_reg.wideSelect;

    // ------------------------------------------------------------
    // flag sources
    // ------------------------------------------------------------
    always_comb begin
        overflowLevel = tpcs_pkg::COUNT_MAX;
        unique case (tpcs_pkg::tpcs_wave_t'(waveformModeSelect))
            tpcs_pkg::TPCS_WAVE_NORMAL: overflowLevel = tpcs_pkg::COUNT_MAX;
            tpcs_pkg::TPCS_WAVE_CTC: overflowLevel = tpcs_pkg::COUNT_MAX;
            tpcs_pkg::TPCS_WAVE_FAST_FULL: overflowLevel = tpcs_pkg::COUNT_MAX;
            tpcs_pkg::TPCS_WAVE_PHASE_FULL: overflowLevel = tpcs_pkg::COUNT_BOTTOM;
            tpcs_pkg::TPCS_WAVE_PHASE_CMPA: overflowLevel = tpcs_pkg::COUNT_BOTTOM;
            tpcs_pkg::TPCS_WAVE_FAST_CMPA: overflowLevel = narrowCompareAValue;
            tpcs_pkg::TPCS_WAVE_RSVD_A: overflowLevel = tpcs_pkg::COUNT_MAX;
            tpcs_pkg::TPCS_WAVE_RSVD_B: overflowLevel = tpcs_pkg::COUNT_MAX;
        endcase
    end

    assign overflowHit = narrowCountValue == overflowLevel;

    // narrow events are qualified by the narrow timer clock so a stopped narrow timer stays quiet; wide events pass unqualified
    always_comb begin
        flagSet = 8'h00;
        flagSet[tpcs_pkg::FLAG_NARROW_CMP_A] =
            narrowTimerTick && (narrowCountValue == narrowCompareAValue);
        flagSet[tpcs_pkg::FLAG_NARROW_OVF] = narrowTimerTick && overflowHit;
        flagSet[tpcs_pkg::FLAG_NARROW_CMP_B] =
            narrowTimerTick && (narrowCountValue == narrowCompareBValue);
        flagSet[tpcs_pkg::FLAG_WIDE_CAPTURE] = wideCaptureEvent;
        flagSet[tpcs_pkg::FLAG_WIDE_CMP_B] = wideCompareBEvent;
        flagSet[tpcs_pkg::FLAG_WIDE_CMP_A] = wideCompareAEvent;
        flagSet[tpcs_pkg::FLAG_WIDE_OVF] = wideOverflowEvent;
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setupPhase = psel && !penable;
    assign writeStrobe = psel && penable && pwrite;

    assign addrMapped =
        isAddr(paddr, tpcs_pkg::ADDR_EVENT_FLAGS) ||
        isAddr(paddr, tpcs_pkg::ADDR_GENERAL_CTRL) ||
        isAddr(paddr, tpcs_pkg::ADDR_CLOCK_SELECT) ||
        isAddr(paddr, tpcs_pkg::ADDR_IRQ_ENABLE);

    always_comb begin
        flagClear = flagAck;
        if (writeStrobe && isAddr(paddr, tpcs_pkg::ADDR_EVENT_FLAGS)) begin
            flagClear = flagAck | pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // set wins over a clear in the same cycle
        state_next.eventFlags =
            ((state_reg.eventFlags & ~flagClear) | flagSet)
            & tpcs_pkg::FLAGS_IMPLEMENTED;

        // one-cycle strobe: hardware drops it on the next edge
        state_next.prescalerReset = 1'b0;

        if (writeStrobe) begin
            if (isAddr(paddr, tpcs_pkg::ADDR_GENERAL_CTRL)) begin
                state_next.prescalerReset =
                    pwdata[tpcs_pkg::PRESCALER_RESET_BIT];
            end
            if (isAddr(paddr, tpcs_pkg::ADDR_CLOCK_SELECT)) begin
                state_next.narrowSelect =
                    pwdata[tpcs_pkg::NARROW_CS_LSB +: 3];
                state_next.wideSelect =
                    pwdata[tpcs_pkg::WIDE_CS_LSB +: 3];
            end
            if (isAddr(paddr, tpcs_pkg::ADDR_IRQ_ENABLE)) begin
                state_next.irqEnable =
                    pwdata[7:0] & tpcs_pkg::FLAGS_IMPLEMENTED;
            end
        end

        // read data captured in setup so the access phase needs no wait
        if (setupPhase) begin
            state_next.readData = 32'h0000_0000;
            state_next.readError = !addrMapped;
            if (isAddr(paddr, tpcs_pkg::ADDR_EVENT_FLAGS)) begin
                state_next.readData[7:0] =
                    state_reg.eventFlags & tpcs_pkg::FLAGS_IMPLEMENTED;
            end
            if (isAddr(paddr, tpcs_pkg::ADDR_GENERAL_CTRL)) begin
                state_next.readData[tpcs_pkg::PRESCALER_RESET_BIT] =
                    state_reg.prescalerReset;
            end
            if (isAddr(paddr, tpcs_pkg::ADDR_CLOCK_SELECT)) begin
                state_next.readData[tpcs_pkg::NARROW_CS_LSB +: 3] =
                    state_reg.narrowSelect;
                state_next.readData[tpcs_pkg::WIDE_CS_LSB +: 3] =
                    state_reg.wideSelect;
            end
            if (isAddr(paddr, tpcs_pkg::ADDR_IRQ_ENABLE)) begin
                state_next.readData[7:0] = state_reg.irqEnable;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.eventFlags <= tpcs_pkg::FLAGS_RESET;
            state_reg.prescalerReset <= tpcs_pkg::PRESCALER_RESET_RESET;
            state_reg.narrowSelect <= tpcs_pkg::CLOCK_SELECT_RESET;
            state_reg.wideSelect <= tpcs_pkg::CLOCK_SELECT_RESET;
            state_reg.irqEnable <= tpcs_pkg::IRQ_ENABLE_RESET;
            state_reg.readData <= 32'h0000_0000;
            state_reg.readError <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = state_reg.readData;
    assign pready = 1'b1;
    assign pslverr = psel && penable && state_reg.readError;

    // request lines are level, dropping as soon as any condition fails
    assign irqRequest =
        {8{globalIrqEnable}} & state_reg.irqEnable & state_reg.eventFlags;

endmodule

`default_nettype wire

// >>> testbench/tpcs_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module tpcs_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // timer clock from the block
    input wire logic tick,
    // counter value back to the block
    output logic [7:0] count
);
    // normal mode only: up and wrap, enough to reach both compares and max
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 8'h00;
        end else if (tick) begin
            count <= count + 8'h01;
        end
    end
endmodule

`default_nettype wire

// >>> testbench/tpcs_top_props.sv
`timescale 1ns/10ps
`default_nettype none

module tpcs_top_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // interrupts
    input wire logic globalIrqEnable,
    input wire logic [7:0] flagAck,
    input wire logic [7:0] irqRequest,
    // narrow core
    input wire logic [7:0] narrowCountValue,
    input wire logic [7:0] narrowCompareAValue,
    input wire logic narrowTimerTick,
    input wire logic [2:0] narrowClockSelect,
    input wire logic narrowCountPin
);
    logic [7:0] enMirror_reg;
    logic rdAcc;
    logic hitA;
    logic sel8;
    assign rdAcc = psel && penable && !pwrite;
    assign hitA = narrowTimerTick && narrowCountValue == narrowCompareAValue;
    assign sel8 = narrowClockSelect == tpcs_pkg::TPCS_CS_DIV8;

    // mirror of the enable register, so mask checks need no peek inside
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enMirror_reg <= 8'h00;
        end else if (psel && penable && pwrite && paddr == tpcs_pkg::ADDR_IRQ_ENABLE) begin
            enMirror_reg <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_FLAG_RSVD: assert property (rdAcc && paddr == tpcs_pkg::ADDR_EVENT_FLAGS |-> !prdata[4])
        else $error("flag bit 4 reads one");
    AST_CTRL_RSVD: assert property (rdAcc && paddr == tpcs_pkg::ADDR_GENERAL_CTRL |-> prdata[31:1] == 31'h0)
        else $error("control reserved bits set");
    AST_IRQ_GLOBAL: assert property (!globalIrqEnable |-> irqRequest == 8'h00)
        else $error("request without global enable");
    AST_IRQ_MASK: assert property ((irqRequest & ~enMirror_reg) == 8'h00)
        else $error("request from masked source");
    AST_CMPA_SET: assert property (hitA && enMirror_reg[0] ##1 globalIrqEnable |-> irqRequest[0])
        else $error("compare A match gave no request");
    AST_ACK_CLR: assert property (flagAck[0] && !hitA |=> !irqRequest[0])
        else $error("acknowledge did not clear");
    AST_STOP: assert property (narrowClockSelect == tpcs_pkg::TPCS_CS_STOP |-> !narrowTimerTick)
        else $error("tick while stopped");
    AST_DIV8_GAP: assert property (sel8 && narrowTimerTick |=> (!narrowTimerTick || !sel8) [*7])
        else $error("divide by 8 tick too early");
    AST_FIRST_CNT: assert property ($changed(narrowClockSelect) && sel8 |-> ##[0:8] (narrowTimerTick || !sel8))
        else $error("first prescaled tick late");
    AST_EXT_RISE: assert property (narrowClockSelect == tpcs_pkg::TPCS_CS_EXT_RISE && $rose(narrowCountPin)
        |-> ##[1:3] narrowTimerTick) else $error("pin edge tick late");
    AST_EXT_ONE: assert property (narrowClockSelect == tpcs_pkg::TPCS_CS_EXT_RISE && narrowTimerTick
        |=> !narrowTimerTick) else $error("pin tick longer than one cycle");
endmodule

bind tpcs_top tpcs_top_props i_tpcs_top_props (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .globalIrqEnable, .flagAck, .irqRequest, .narrowCountValue, .narrowCompareAValue, .narrowTimerTick,
    .narrowClockSelect, .narrowCountPin);

`default_nettype wire

// >>> testbench/timer_prescaler_clock_select_bench.sv
`timescale 1ns/10ps
`default_nettype none

module timer_prescaler_clock_select_bench;
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic globalIrqEnable = 1'b0, narrowTimerTick, wideTimerTick, narrowCountPin = 1'b0, wideCountPin = 1'b0;
    logic wideOverflowEvent = 1'b0, wideCompareAEvent = 1'b0, wideCompareBEvent = 1'b0, wideCaptureEvent = 1'b0;
    logic [7:0] flagAck = 8'h00, irqRequest, narrowCountValue;
    logic [7:0] narrowCompareAValue = 8'h05, narrowCompareBValue = 8'h09;
    logic [2:0] waveformModeSelect = 3'b000, narrowClockSelect, wideClockSelect;
    int n_mismatch = 0, checked = 0, cyc = 0, nN, nW;
    int dv[6] = '{0, 1, 8, 64, 256, 1024};

    tpcs_top i_tpcs_top (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .globalIrqEnable, .flagAck, .irqRequest, .narrowCountValue, .narrowCompareAValue, .narrowCompareBValue,
        .waveformModeSelect, .narrowTimerTick, .narrowClockSelect, .wideOverflowEvent, .wideCompareAEvent,
        .wideCompareBEvent, .wideCaptureEvent, .wideTimerTick, .wideClockSelect, .narrowCountPin, .wideCountPin);
    tpcs_core_model i_tpcs_core_model (.clk, .reset_n, .tick(narrowTimerTick), .count(narrowCountValue));

    // ----------------------------------------
    // clock, watchdog and helpers
    // ----------------------------------------
    always #5 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one idle edge after each transfer, so no signal is driven twice per step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            nN += int'(narrowTimerTick);
            nW += int'(wideTimerTick);
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdchk(tpcs_pkg::ADDR_EVENT_FLAGS, 32'h0);
        apb(1'b1, tpcs_pkg::ADDR_GENERAL_CTRL, 32'hfe);
        rdchk(tpcs_pkg::ADDR_GENERAL_CTRL, 32'h0);
        apb(1'b1, tpcs_pkg::ADDR_GENERAL_CTRL, 32'h01);
        rdchk(tpcs_pkg::ADDR_GENERAL_CTRL, 32'h0);
        rdchk(12'h0f0, 32'h0);
        check(err, 1'b1);
        $display("t_regs done");
    endtask

    task automatic t_flags;
        globalIrqEnable <= 1'b1;
        apb(1'b1, tpcs_pkg::ADDR_IRQ_ENABLE, 32'hff);
        rdchk(tpcs_pkg::ADDR_IRQ_ENABLE, 32'hef);
        waveformModeSelect <= 3'b111;
        apb(1'b1, tpcs_pkg::ADDR_CLOCK_SELECT, 32'h01);
        repeat (6) @(posedge clk);
        rdchk(tpcs_pkg::ADDR_EVENT_FLAGS, 32'h03);
        waveformModeSelect <= 3'b000;
        repeat (300) @(posedge clk);
        apb(1'b1, tpcs_pkg::ADDR_CLOCK_SELECT, 32'h00);
        rdchk(tpcs_pkg::ADDR_EVENT_FLAGS, 32'h07);
        check(irqRequest, 8'h07);
        globalIrqEnable <= 1'b0;
        apb(1'b1, tpcs_pkg::ADDR_IRQ_ENABLE, 32'h02);
        check(irqRequest, 8'h00);
        globalIrqEnable <= 1'b1;
        apb(1'b1, tpcs_pkg::ADDR_EVENT_FLAGS, 32'h12);
        rdchk(tpcs_pkg::ADDR_EVENT_FLAGS, 32'h05);
        flagAck <= 8'h05;
        @(posedge clk);
        flagAck <= 8'h00;
        {wideOverflowEvent, wideCompareAEvent, wideCompareBEvent, wideCaptureEvent} <= 4'hf;
        @(posedge clk);
        {wideOverflowEvent, wideCompareAEvent, wideCompareBEvent, wideCaptureEvent} <= 4'h0;
        rdchk(tpcs_pkg::ADDR_EVENT_FLAGS, 32'he8);
        check(irqRequest, 8'h00);
        globalIrqEnable <= 1'b0;
        $display("t_flags done");
    endtask

    task automatic t_prescale;
        for (int k = 1; k <= 5; k++) begin
            apb(1'b1, tpcs_pkg::ADDR_CLOCK_SELECT, 32'(k + 16 * (k % 5 + 1)));
            nN = 0;
            nW = 0;
            step(2048);
            check(nN, 2048 / dv[k]);
            check(nW, 2048 / dv[k % 5 + 1]);
        end
        $display("t_prescale done");
    endtask

    // a clear restarts the divider: the next tick comes later than free running would
    task automatic t_psr;
        int n;
        n = 0;
        while (narrowTimerTick !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        apb(1'b1, tpcs_pkg::ADDR_GENERAL_CTRL, 32'h01);
        n = 0;
        while (narrowTimerTick !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check(n, 8);
        $display("t_psr done");
    endtask

    // pins stay low across select changes; half period of four cycles
    task automatic t_ext;
        apb(1'b1, tpcs_pkg::ADDR_CLOCK_SELECT, 32'h67);
        check(wideClockSelect, 3'h6);
        nN = 0;
        nW = 0;
        repeat (10) begin
            narrowCountPin <= 1'b1;
            wideCountPin <= 1'b1;
            step(4);
            narrowCountPin <= 1'b0;
            wideCountPin <= 1'b0;
            step(4);
        end
        step(4);
        check(nN, 10);
        check(nW, 10);
        apb(1'b1, tpcs_pkg::ADDR_CLOCK_SELECT, 32'h00);
        $display("t_ext done");
    endtask

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_flags;
        t_prescale;
        apb(1'b1, tpcs_pkg::ADDR_CLOCK_SELECT, 32'h02);
        t_psr;
        t_ext;
        tally_and_finish;
    end
endmodule

`default_nettype wire
